// ==== rtl/pulse_gen_pkg.sv ====
// constants and register layout for the programmable pulse generator
package pulse_gen_pkg;
  localparam logic [7:0] CTRL0_ADDR     = 8'hb1;
  localparam logic [7:0] CTRL2_ADDR     = 8'hb2;
  localparam logic [7:0] RELOAD_LO_ADDR = 8'hb3;
  localparam logic [7:0] TIMER_LO_ADDR  = 8'hb6;
  localparam logic [7:0] TIMER_HI_ADDR  = 8'hb7;
  localparam logic [7:0] COUNT_ADDR     = 8'hb4;
  localparam int OUT_EN_BIT   = 7;
  localparam int RELOAD_BIT   = 6;
  localparam int STYLE_BIT    = 4;
  localparam int DIV_BIT      = 3;
  localparam int CNT_EN_BIT   = 2;
  localparam int CNT_CLR_BIT  = 1;
  localparam int EDGE_BIT     = 0;
  localparam int RATE_HI      = 7;
  localparam int RATE_LO      = 6;
  localparam int DEC_HI       = 5;
  localparam int TOP_BIT      = 0;
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL0_MASK  = 8'hdf;
  localparam logic [7:0] CTRL2_MASK  = 8'hf1;
  localparam logic [8:0] WORK_RESET  = 9'h000;
  localparam logic [1:0] DIV2_LAST   = 2'h1;
  localparam logic [1:0] DIV4_LAST   = 2'h3;
  // approach step period in generator ticks: 512 shifted by the rate field
  localparam logic [12:0] RATE_BASE  = 13'h0200;
  localparam logic [12:0] ONE_TICK   = 13'h0001;
endpackage

// ==== rtl/pulse_edge_sync.sv ====
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module pulse_edge_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      rise_o,
  output logic      fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } sync_s;
  sync_s st;
  sync_s next_st;
  always_comb begin
    next_st = st;
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    // level moves only when stages two and three agree
    if (st.s2 == st.s3 && st.s3 != st.level) begin
      next_st.level = st.s3;
      next_st.rise = st.s3;
      next_st.fall = ~st.s3;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign rise_o = st.rise;
  assign fall_o = st.fall;
endmodule
`default_nettype wire

// ==== rtl/pulse_gen_ctrl.sv ====
// control logic of the programmable pulse generator
//
// Behaviour
// - single pulse mode: writing one to enable gives exactly one pulse.
// - single pulse mode: hardware clears enable when the timer times up.
// - synchronous mode: one pulse per trigger comparator event while enabled and no pulse is active.
// - reload style zero: working value follows reload value directly.
// - reload style one: working value steps toward reload at chosen rate.
// - bit 4 selects single pulse (0) or synchronous (1) operation.
// - generator clock is system clock over two (0) or four (1).
// - trigger events are counted only while count enable is one.
// - writing one to count clear resets counter; bit self-clears.
// - edge select: falling edges when zero, rising edges when one.
// - synchronous, decrement style 0x: stop event clears enable, halts pulse.
// - reload buffer is nine bits; bit 8 lives in a separate register.
`timescale 1ns/1ps
`default_nettype none
module pulse_gen_ctrl
  import pulse_gen_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  input  wire logic       TRIG_CMP_I,
  input  wire logic       STOP_CMP_I,
  output logic      [7:0] RDATA_O,
  output logic            PULSE_O
);
  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl2;
    logic [7:0]  reload_lo;
    logic [8:0]  work;
    logic [8:0]  pulse_timer;
    logic [1:0]  div_cnt;
    logic [12:0] rate_cnt;
    logic [7:0]  event_count;
    logic        busy;
    logic        pulse;
    logic [7:0]  rdata;
  } gen_s;
  gen_s st;
  gen_s next_st;

  logic trig_rise;
  logic trig_fall;
  logic stop_rise;
  logic tick;
  logic trig_event;
  logic [8:0]  reload_val;
  logic [12:0] rate_period;

  pulse_edge_sync u_trig_sync (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .async_i (TRIG_CMP_I),
    .rise_o  (trig_rise),
    .fall_o  (trig_fall)
  );
  pulse_edge_sync u_stop_sync (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .async_i (STOP_CMP_I),
    .rise_o  (stop_rise),
    .fall_o  ()
  );
  assign reload_val = {st.ctrl2[TOP_BIT], st.reload_lo};
  assign tick = st.ctrl0[DIV_BIT] ? (st.div_cnt == DIV4_LAST)
                                  : (st.div_cnt == DIV2_LAST);
  assign trig_event = st.ctrl0[EDGE_BIT] ? trig_rise : trig_fall;
  assign rate_period = RATE_BASE << st.ctrl2[RATE_HI:RATE_LO];

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    next_st.div_cnt = tick ? 2'h0 : st.div_cnt + 2'h1;

    if (!st.ctrl0[RELOAD_BIT]) begin
      next_st.work = reload_val;
      next_st.rate_cnt = 13'h0000;
    end else if (tick) begin
      // gradual approach, one step per period
      if (st.rate_cnt + ONE_TICK >= rate_period) begin
        next_st.rate_cnt = 13'h0000;
        if (st.work < reload_val) begin
          next_st.work = st.work + 9'h001;
        end else if (st.work > reload_val) begin
          next_st.work = st.work - 9'h001;
        end
      end else begin
        next_st.rate_cnt = st.rate_cnt + ONE_TICK;
      end
    end

    // timer advances on generator ticks while a pulse is active
    if (st.busy && tick) begin
      if (st.pulse_timer + 9'h001 >= st.work) begin
        next_st.busy = 1'b0;
        next_st.pulse_timer = 9'h000;
        // single pulse ends and clears enable
        if (!st.ctrl0[STYLE_BIT]) begin
          next_st.ctrl0[OUT_EN_BIT] = 1'b0;
        end
      end else begin
        next_st.pulse_timer = st.pulse_timer + 9'h001;
      end
    end

    // each trigger event while enabled and no pulse is active starts a pulse in synchronous mode
    if (st.ctrl0[STYLE_BIT] && st.ctrl0[OUT_EN_BIT] && trig_event
        && !st.busy) begin
      next_st.busy = 1'b1;
      next_st.pulse_timer = 9'h000;
    end

    if (st.ctrl0[CNT_EN_BIT] && trig_event) begin
      next_st.event_count = st.event_count + 8'h01;
    end
    // clear is a one-cycle self-clearing bit
    if (st.ctrl0[CNT_CLR_BIT]) begin
      next_st.event_count = 8'h00;
      next_st.ctrl0[CNT_CLR_BIT] = 1'b0;
    end

    // stop event halts output without decrement
    if (st.ctrl0[STYLE_BIT] && !st.ctrl2[DEC_HI] && stop_rise) begin
      next_st.ctrl0[OUT_EN_BIT] = 1'b0;
      next_st.busy = 1'b0;
      next_st.pulse_timer = 9'h000;
    end

    if (WR_I) begin
      case (ADDR_I)
        CTRL0_ADDR: begin
          next_st.ctrl0 = WDATA_I & CTRL0_MASK;
          // a write of one fires exactly one pulse
          if (!WDATA_I[STYLE_BIT] && WDATA_I[OUT_EN_BIT] && !st.busy) begin
            next_st.busy = 1'b1;
            next_st.pulse_timer = 9'h000;
          end
        end
        CTRL2_ADDR:     next_st.ctrl2 = WDATA_I & CTRL2_MASK;
        RELOAD_LO_ADDR: next_st.reload_lo = WDATA_I;
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end

    if (RD_I) begin
      case (ADDR_I)
        CTRL0_ADDR:     next_st.rdata = st.ctrl0;
        CTRL2_ADDR:     next_st.rdata = st.ctrl2;
        RELOAD_LO_ADDR: next_st.rdata = st.reload_lo;
        TIMER_LO_ADDR:  next_st.rdata = st.pulse_timer[7:0];
        TIMER_HI_ADDR:  next_st.rdata = {7'h00, st.pulse_timer[8]};
        COUNT_ADDR:     next_st.rdata = st.event_count;
        default:        next_st.rdata = 8'h00;
      endcase
    end

    // output high while the pulse is active
    next_st.pulse = next_st.busy;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA_O = st.rdata;
  assign PULSE_O = st.pulse;

  property p_single_clear;
    @(posedge CLK_I) disable iff (RST_I)
      (st.busy && !st.ctrl0[STYLE_BIT] && tick && !WR_I
       && (st.pulse_timer + 9'h001 >= st.work))
      |=> (!st.ctrl0[OUT_EN_BIT] && !PULSE_O);
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("single pulse did not clear enable");

  property p_write_fires;
    @(posedge CLK_I) disable iff (RST_I)
      (WR_I && ADDR_I == CTRL0_ADDR && WDATA_I[OUT_EN_BIT]
       && !WDATA_I[STYLE_BIT] && !st.busy) |=> PULSE_O;
  endproperty
  a_write_fires: assert property (p_write_fires)
    else $error("enable write did not start a pulse");

  property p_sync_fire;
    @(posedge CLK_I) disable iff (RST_I)
      (st.ctrl0[STYLE_BIT] && st.ctrl0[OUT_EN_BIT] && trig_event
       && !st.busy && !stop_rise && !WR_I) |=> st.busy;
  endproperty
  a_sync_fire: assert property (p_sync_fire)
    else $error("trigger event did not start pulse");

  property p_direct;
    @(posedge CLK_I) disable iff (RST_I)
      (!st.ctrl0[RELOAD_BIT] && !WR_I) |=> st.work == $past(reload_val);
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct reload mismatch");

  property p_step;
    @(posedge CLK_I) disable iff (RST_I)
      st.ctrl0[RELOAD_BIT] |=>
        (st.work == $past(st.work) || st.work == $past(st.work) + 9'h001
         || st.work == $past(st.work) - 9'h001);
  endproperty
  a_step: assert property (p_step)
    else $error("approach jumped by more than one");

  property p_count_off;
    @(posedge CLK_I) disable iff (RST_I)
      (!st.ctrl0[CNT_EN_BIT] && !st.ctrl0[CNT_CLR_BIT])
      |=> st.event_count == $past(st.event_count);
  endproperty
  a_count_off: assert property (p_count_off)
    else $error("counter moved while disabled");

  property p_clear;
    @(posedge CLK_I) disable iff (RST_I)
      st.ctrl0[CNT_CLR_BIT] |=> (st.event_count == 8'h00);
  endproperty
  a_clear: assert property (p_clear)
    else $error("count clear failed");

  property p_stop;
    @(posedge CLK_I) disable iff (RST_I)
      (st.ctrl0[STYLE_BIT] && !st.ctrl2[DEC_HI] && stop_rise && !WR_I)
      |=> (!st.ctrl0[OUT_EN_BIT] && !PULSE_O);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop event did not halt output");

  property p_div;
    @(posedge CLK_I) disable iff (RST_I)
      (tick && !st.ctrl0[DIV_BIT]) |=> !tick ##1 (tick || st.ctrl0[DIV_BIT]);
  endproperty
  a_div: assert property (p_div)
    else $error("divide by two spacing wrong");

  sequence s_no_write_three;
    !WR_I ##1 !WR_I ##1 !WR_I;
  endsequence
  property p_div4;
    @(posedge CLK_I) disable iff (RST_I)
      (tick && st.ctrl0[DIV_BIT] && !WR_I) ##1 s_no_write_three
      |=> (tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3));
  endproperty
  a_div4: assert property (p_div4)
    else $error("divide by four spacing wrong");

  property p_edge_ignore;
    @(posedge CLK_I) disable iff (RST_I)
      (!st.ctrl0[CNT_CLR_BIT]
       && (st.ctrl0[EDGE_BIT] ? trig_fall : trig_rise))
      |=> st.event_count == $past(st.event_count);
  endproperty
  a_edge_ignore: assert property (p_edge_ignore)
    else $error("event counted on the unselected edge");

  property p_single_idle;
    @(posedge CLK_I) disable iff (RST_I)
      (!st.ctrl0[STYLE_BIT] && !st.busy && !WR_I) |=> !PULSE_O;
  endproperty
  a_single_idle: assert property (p_single_idle)
    else $error("pulse started without a write in single mode");

  property p_timer_hold;
    @(posedge CLK_I) disable iff (RST_I)
      (st.busy && !tick && !stop_rise && !WR_I)
      |=> st.pulse_timer == $past(st.pulse_timer);
  endproperty
  a_timer_hold: assert property (p_timer_hold)
    else $error("pulse timer moved between generator ticks");
endmodule
`default_nettype wire

// ==== sim/pulse_cmp_model.sv ====
// comparator partner model: trigger and stop levels
`timescale 1ns/1ps
`default_nettype none
module pulse_cmp_model (
  input  wire logic clk_i,
  output logic      trig_o,
  output logic      stop_o
);
  initial begin
    trig_o = 1'b0;
    stop_o = 1'b0;
  end
  // level held past the sync filter
  task automatic drv(input bit stp, input logic v);
    @(negedge clk_i);
    if (stp) begin
      stop_o = v;
    end else begin
      trig_o = v;
    end
    repeat (16) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== sim/programmable_pulse_generator_ctrl_tb.sv ====
// self-checking bench for the pulse generator control
`timescale 1ns/1ps
`default_nettype none
module programmable_pulse_generator_ctrl_tb;
  import pulse_gen_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       trig;
  logic       stop;
  logic [7:0] rdata;
  logic       pulse;
  int         mismatches = 0;
  int         samples_checked = 0;
  int         npulse = 0;
  int         hi = 0;
  int         width = 0;
  int         base;

  initial begin
    forever #50 clk = ~clk;
  end

  pulse_gen_ctrl pulse_gen_ctrl_i (
    .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .TRIG_CMP_I(trig), .STOP_CMP_I(stop),
    .RDATA_O(rdata), .PULSE_O(pulse));
  pulse_cmp_model pulse_cmp_model_i (
    .clk_i(clk), .trig_o(trig), .stop_o(stop));

  // pulses are counted at their end, width in system cycles
  always @(negedge clk) begin
    if (pulse === 1'b1) begin
      hi <= hi + 1;
    end else if (hi != 0) begin
      npulse <= npulse + 1;
      width <= hi;
      hi <= 0;
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e,
                     input string m);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic cw(input int lo, input int up, input string m);
    samples_checked++;
    if (width < lo || width > up) begin
      mismatches++;
      $display("[FAIL] %0t %s width %0d", $time, m, width);
    end
  endtask

  task automatic rr(input logic [7:0] a, input int lo, input int up,
                    input string m);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    samples_checked++;
    if ($isunknown(rdata) || rdata < lo || rdata > up) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h", $time, m, rdata);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e,
                    input string m);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, e, m);
  endtask

  task automatic wait_low(input int lim);
    int k;
    k = 0;
    repeat (2) @(negedge clk);
    while (pulse !== 1'b0 && k < lim) begin
      @(negedge clk);
      k++;
    end
    if (k >= lim) begin
      mismatches++;
      $display("[FAIL] %0t pulse stuck high", $time);
      finish_test();
    end
    @(negedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rc(CTRL0_ADDR, CTRL0_RESET, "ctrl0 reset");
    rc(COUNT_ADDR, 8'h00, "count reset");
    rc(8'ha0, 8'h00, "unmapped read");
    $display("test reset done");
    // single pulse, w=5 at /2 then /4
    wr_reg(RELOAD_LO_ADDR, 8'h05);
    wr_reg(CTRL2_ADDR, 8'h00);
    wr_reg(CTRL0_ADDR, 8'h80);
    wait_low(100);
    cw(8, 12, "div2");
    rc(CTRL0_ADDR, 8'h00, "enable self clear");
    repeat (40) @(negedge clk);
    chk(8'(npulse), 8'h01, "one pulse");
    wr_reg(CTRL0_ADDR, 8'h88);
    wait_low(200);
    cw(16, 24, "div4");
    rc(CTRL0_ADDR, 8'h08, "enable clear div4");
    chk(8'(npulse), 8'h02, "second pulse");
    // top reload bit lives in the second control register
    wr_reg(CTRL2_ADDR, 8'h01);
    wr_reg(RELOAD_LO_ADDR, 8'hff);
    rc(CTRL2_ADDR, 8'h01, "top bit");
    wr_reg(CTRL0_ADDR, 8'h80);
    // about 300 ticks in, so the timer has passed bit 8
    repeat (600) @(negedge clk);
    rr(TIMER_LO_ADDR, 43, 46, "timer low");
    rc(TIMER_HI_ADDR, 8'h01, "timer high");
    wait_low(1200);
    cw(1020, 1024, "nine bit width");
    $display("test single done");
    // synchronous events on each edge, count then clear
    wr_reg(CTRL2_ADDR, 8'h00);
    wr_reg(RELOAD_LO_ADDR, 8'h02);
    for (int e = 0; e < 2; e++) begin
      base = npulse;
      wr_reg(CTRL0_ADDR, 8'h96 | 8'(e));
      rc(CTRL0_ADDR, 8'h94 | 8'(e), "clear self");
      pulse_cmp_model_i.drv(1'b0, 1'b1);
      rc(COUNT_ADDR, 8'(e), "after rise");
      pulse_cmp_model_i.drv(1'b0, 1'b0);
      rc(COUNT_ADDR, 8'h01, "after fall");
      pulse_cmp_model_i.drv(1'b0, 1'b1);
      pulse_cmp_model_i.drv(1'b0, 1'b0);
      rc(COUNT_ADDR, 8'h02, "two events");
      chk(8'(npulse - base), 8'h02, "sync pulses");
    end
    base = npulse;
    wr_reg(CTRL0_ADDR, 8'h91);
    pulse_cmp_model_i.drv(1'b0, 1'b1);
    pulse_cmp_model_i.drv(1'b0, 1'b0);
    rc(COUNT_ADDR, 8'h02, "count off");
    chk(8'(npulse - base), 8'h01, "pulse uncounted");
    wr_reg(CTRL0_ADDR, 8'h93);
    rc(COUNT_ADDR, 8'h00, "count cleared");
    wr_reg(COUNT_ADDR, 8'h55);
    rc(COUNT_ADDR, 8'h00, "count read only");
    rc(CTRL0_ADDR, 8'h91, "clear bit low");
    $display("test sync done");
    // stop event in mid pulse, w=200
    wr_reg(RELOAD_LO_ADDR, 8'hc8);
    pulse_cmp_model_i.drv(1'b0, 1'b1);
    pulse_cmp_model_i.drv(1'b1, 1'b1);
    chk({7'h00, pulse}, 8'h00, "stop halts");
    rc(CTRL0_ADDR, 8'h11, "stop clears enable");
    pulse_cmp_model_i.drv(1'b1, 1'b0);
    pulse_cmp_model_i.drv(1'b0, 1'b0);
    // decrement style 1x keeps the enable on a stop event
    wr_reg(CTRL2_ADDR, 8'h20);
    wr_reg(CTRL0_ADDR, 8'h91);
    pulse_cmp_model_i.drv(1'b1, 1'b1);
    rc(CTRL0_ADDR, 8'h91, "stop ignored in decrement style");
    pulse_cmp_model_i.drv(1'b1, 1'b0);
    wr_reg(CTRL2_ADDR, 8'h00);
    $display("test stop done");
    // approach: 1024 cycles per step, so 2 to 10 needs 8 steps
    wr_reg(RELOAD_LO_ADDR, 8'h02);
    wr_reg(CTRL0_ADDR, 8'hd1);
    wr_reg(RELOAD_LO_ADDR, 8'h0a);
    pulse_cmp_model_i.drv(1'b0, 1'b1);
    pulse_cmp_model_i.drv(1'b0, 1'b0);
    cw(2, 8, "no jump");
    repeat (12000) @(negedge clk);
    pulse_cmp_model_i.drv(1'b0, 1'b1);
    pulse_cmp_model_i.drv(1'b0, 1'b0);
    cw(18, 22, "approached");
    // rate one: 2048 cycles per step; direct mode restarts the phase
    wr_reg(CTRL2_ADDR, 8'h40);
    wr_reg(CTRL0_ADDR, 8'h91);
    wr_reg(CTRL0_ADDR, 8'hd1);
    wr_reg(RELOAD_LO_ADDR, 8'h08);
    repeat (1500) @(negedge clk);
    pulse_cmp_model_i.drv(1'b0, 1'b1);
    pulse_cmp_model_i.drv(1'b0, 1'b0);
    cw(19, 21, "slow rate holds");
    repeat (3000) @(negedge clk);
    pulse_cmp_model_i.drv(1'b0, 1'b1);
    pulse_cmp_model_i.drv(1'b0, 1'b0);
    cw(15, 17, "slow rate reached");
    $display("test approach done");
    finish_test();
  end
endmodule
`default_nettype wire
